/* include/opmsel_cfg.svh */
// Constants for the operation mode selector
`ifndef OPMSEL_CFG_SVH
`define OPMSEL_CFG_SVH
`define OPMSEL_SEL_EXT_PU    3'h0
`define OPMSEL_SEL_PU_FIX    3'h1
`define OPMSEL_SEL_EXT_FIX   3'h2
`define OPMSEL_SEL_COMB1     3'h3
`define OPMSEL_SEL_COMB2     3'h4
`define OPMSEL_SEL_SWITCH    3'h6
`define OPMSEL_SEL_ILOCK     3'h7
`define OPMSEL_SEL_UNSUP     3'h5
`define OPMSEL_SEL_RESET     3'h0
`define OPMSEL_FN_ILOCK      8'h0C
`define OPMSEL_FN_OSTOP      8'h18
`define OPMSEL_POL_INVERT    2'h2
`define OPMSEL_PAR_MODESEL   8'h4F
`endif

/* include/opmsel_pkg.sv */
// Types for the operation mode selector
package opmsel_pkg;
   typedef enum logic [4:0] {
      OPMSEL_EXT  = 5'h01,
      OPMSEL_PU   = 5'h02,
      OPMSEL_NET  = 5'h04,
      OPMSEL_CMB1 = 5'h08,
      OPMSEL_CMB2 = 5'h10
   } opmsel_mode_t;
   typedef struct packed {
      logic        fwd;
      logic        rev;
      logic [15:0] freq;
   } opmsel_cmd_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] number;
      logic       writable_ext;
      logic       protect_ok;
   } opmsel_pwr_t;
endpackage

/* design/opmsel_top.sv */
// Operation mode selector: mode state machine and command source mux
`timescale 1ns/100ps
`include "opmsel_cfg.svh"
module opmsel_top #(
   parameter int FREQ_W = 16,
   parameter int N_ASSIGN = 5
) (
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   reset,
   // Mode-select setting write
   input  wire logic                   mode_select_write,
   input  wire logic [2:0]             mode_select_value,
   input  wire logic                   motor_running,
   // Mode requests
   input  wire logic                   panel_ext_key,
   input  wire logic                   panel_select_key,
   input  wire logic                   net_to_ext_cmd,
   input  wire logic                   net_to_net_cmd,
   // Terminal assignment and interlock
   input  wire logic [N_ASSIGN*8-1:0]  input_function_assign_settings,
   input  wire logic [1:0]             output_stop_polarity_setting,
   input  wire logic                   panel_interlock_input,
   input  wire logic                   output_stop_input,
   // Command sources
   input  wire logic                   forward_start_input,
   input  wire logic                   reverse_start_input,
   input  wire logic                   current_input_select,
   input  wire logic                   multi_speed_active,
   input  wire logic                   jog_active,
   input  wire logic [FREQ_W-1:0]      analog_freq,
   input  wire logic [FREQ_W-1:0]      current_freq,
   input  wire logic [FREQ_W-1:0]      multi_speed_freq,
   input  wire logic [FREQ_W-1:0]      panel_freq,
   input  wire logic                   panel_fwd_key,
   input  wire logic                   panel_rev_key,
   input  wire opmsel_pkg::opmsel_cmd_t net_cmd,
   // Parameter write request
   input  wire opmsel_pkg::opmsel_pwr_t param_write,
   // Outputs
   output opmsel_pkg::opmsel_mode_t    mode,
   output logic [2:0]                  mode_select_setting,
   output opmsel_pkg::opmsel_cmd_t     drive_cmd,
   output logic                        output_stop,
   output logic                        param_write_accept,
   output logic                        param_write_reject
);
   import opmsel_pkg::*;

   generate
      if (FREQ_W != 16 || N_ASSIGN < 1) begin : g_bad_param
         $error("opmsel_top: FREQ_W must be 16 and N_ASSIGN at least 1");
      end
   endgenerate

   opmsel_mode_t next_mode;
   logic [2:0]   sel;
   logic         held_valid;
   opmsel_cmd_t  held_cmd;
   logic         init_done;

   assign sel = mode_select_setting;

   // Interlock source
   logic [N_ASSIGN-1:0] has_ilock_bits;
   logic [N_ASSIGN-1:0] has_ostop_bits;
   genvar g;
   generate
      for (g = 0; g < N_ASSIGN; g++) begin : g_assign
         assign has_ilock_bits[g] =
            input_function_assign_settings[g*8 +: 8] == `OPMSEL_FN_ILOCK;
         assign has_ostop_bits[g] =
            input_function_assign_settings[g*8 +: 8] == `OPMSEL_FN_OSTOP;
      end
   endgenerate
   wire has_ilock = |has_ilock_bits;
   wire has_ostop = |has_ostop_bits;
   wire ostop_level = (output_stop_polarity_setting == `OPMSEL_POL_INVERT) ?
                      ~output_stop_input : output_stop_input;
   wire ostop_is_ilock = ~has_ilock & has_ostop;
   wire ilock_on = has_ilock ? panel_interlock_input :
                   ostop_is_ilock ? ostop_level : 1'b1;
   wire ilock_mode = (sel == `OPMSEL_SEL_ILOCK);
   wire start_on = forward_start_input | reverse_start_input;

   // Mode-select write filter; value 5 is unsupported
   wire sel_ok = (mode_select_value != `OPMSEL_SEL_UNSUP);
   wire sel_take = mode_select_write & sel_ok & ~motor_running;

   // Mode derived purely from a fixed setting
   opmsel_mode_t fixed_mode;
   always_comb begin
      fixed_mode = OPMSEL_EXT;
      case (sel)
         `OPMSEL_SEL_PU_FIX: fixed_mode = OPMSEL_PU;
         `OPMSEL_SEL_COMB1:  fixed_mode = OPMSEL_CMB1;
         `OPMSEL_SEL_COMB2:  fixed_mode = OPMSEL_CMB2;
         default:            fixed_mode = OPMSEL_EXT;
      endcase
   end

   // Switch permissions
   wire run_ok = ~motor_running | (sel == `OPMSEL_SEL_SWITCH);
   wire may_pu = run_ok & ((sel == `OPMSEL_SEL_EXT_PU) | (sel == `OPMSEL_SEL_SWITCH) |
                 (ilock_mode & ilock_on & ~start_on));
   wire may_net = run_ok & ((sel == `OPMSEL_SEL_EXT_PU) | (sel == `OPMSEL_SEL_EXT_FIX) |
                  (sel == `OPMSEL_SEL_SWITCH) | ilock_mode);
   wire may_ext = run_ok & ((sel == `OPMSEL_SEL_EXT_PU) | (sel == `OPMSEL_SEL_EXT_FIX) |
                  (sel == `OPMSEL_SEL_SWITCH) | ilock_mode);
   wire switchable = (sel == `OPMSEL_SEL_EXT_PU) | (sel == `OPMSEL_SEL_EXT_FIX) |
                     (sel == `OPMSEL_SEL_SWITCH) | ilock_mode;

   always_comb begin
      next_mode = mode;
      if (!switchable) begin
         next_mode = fixed_mode;
      end else if (ilock_mode && !ilock_on) begin
         next_mode = OPMSEL_EXT;
      end else begin
         case (mode)
            OPMSEL_EXT: begin
               if (panel_ext_key && may_pu) begin
                  next_mode = OPMSEL_PU;
               end else if (net_to_net_cmd && may_net) begin
                  next_mode = OPMSEL_NET;
               end
            end
            OPMSEL_PU: begin
               if (panel_ext_key && may_ext) begin
                  next_mode = OPMSEL_EXT;
               end else if (net_to_net_cmd && may_net) begin
                  next_mode = OPMSEL_NET;
               end
            end
            OPMSEL_NET: begin
               if (net_to_ext_cmd && may_ext) begin
                  next_mode = OPMSEL_EXT;
               end else if (panel_select_key && may_pu) begin
                  next_mode = OPMSEL_PU;
               end
            end
            default: next_mode = OPMSEL_EXT;
         endcase
         if (sel == `OPMSEL_SEL_EXT_FIX && next_mode == OPMSEL_PU) begin
            next_mode = mode;
         end
      end
   end

   // Terminal-sourced command
   opmsel_cmd_t ext_cmd;
   wire [FREQ_W-1:0] ext_freq = multi_speed_active ? multi_speed_freq :
                              current_input_select ? current_freq : analog_freq;
   assign ext_cmd = '{fwd: forward_start_input, rev: reverse_start_input,
                      freq: ext_freq};

   // Panel-sourced command; held value carried over a running switch
   opmsel_cmd_t pu_cmd;
   assign pu_cmd = held_valid ? held_cmd :
                   '{fwd: panel_fwd_key, rev: panel_rev_key, freq: panel_freq};

   opmsel_cmd_t next_cmd;
   always_comb begin
      next_cmd = ext_cmd;
      case (mode)
         OPMSEL_EXT: next_cmd = ext_cmd;
         OPMSEL_PU:  next_cmd = pu_cmd;
         OPMSEL_NET: next_cmd = held_valid ? held_cmd : net_cmd;
         OPMSEL_CMB1: begin
            next_cmd.fwd = forward_start_input;
            next_cmd.rev = reverse_start_input;
            next_cmd.freq = multi_speed_active ? multi_speed_freq :
                            current_input_select ? current_freq : panel_freq;
         end
         OPMSEL_CMB2: begin
            next_cmd.fwd = panel_fwd_key;
            next_cmd.rev = panel_rev_key;
            next_cmd.freq = ext_freq;
         end
         default: next_cmd = ext_cmd;
      endcase
   end

   // Carry-over capture on a mode change into panel or network mode while running
   wire changing = (next_mode != mode) && motor_running;
   wire carry = changing && (next_mode == OPMSEL_PU || next_mode == OPMSEL_NET);
   wire clear_hold = (next_mode != mode) && !carry;
   // Operator input on the new source releases the carried command
   wire release_hold = (mode == OPMSEL_PU && (panel_fwd_key | panel_rev_key)) ||
                       (mode == OPMSEL_NET && net_to_net_cmd);

   // Parameter write gate
   wire pw_mode_sel = (param_write.number == `OPMSEL_PAR_MODESEL);
   wire pw_ok = pw_mode_sel ? param_write.protect_ok :
                (ilock_mode && !ilock_on) ? 1'b0 :
                (mode == OPMSEL_EXT) ? (param_write.writable_ext &
                                        param_write.protect_ok) :
                param_write.protect_ok;

   // Output stop: interlock stop in external mode, plus the plain stop input
   // Only a real interlock source stops output; the default-on case would lock it
   wire ilock_src  = has_ilock | ostop_is_ilock;
   wire ilock_stop = ilock_mode & ilock_src & ilock_on & (mode == OPMSEL_EXT);
   wire plain_stop = has_ostop & ~(ilock_mode & ostop_is_ilock) & ostop_level;
   wire next_stop  = ilock_stop | plain_stop;

   always_ff @(posedge clock) begin
      if (reset) begin
         mode_select_setting <= `OPMSEL_SEL_RESET;
         init_done <= 1'b0;
      end else begin
         init_done <= 1'b1;
         if (sel_take) begin
            mode_select_setting <= mode_select_value;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mode <= OPMSEL_EXT;
      end else if (!init_done) begin
         mode <= fixed_mode;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         held_valid <= 1'b0;
         held_cmd   <= '0;
      end else if (carry) begin
         held_valid <= 1'b1;
         held_cmd   <= drive_cmd;
      end else if (clear_hold || release_hold) begin
         held_valid <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         drive_cmd          <= '0;
         output_stop        <= 1'b0;
         param_write_accept <= 1'b0;
         param_write_reject <= 1'b0;
      end else begin
         drive_cmd          <= next_cmd;
         output_stop        <= next_stop;
         param_write_accept <= param_write.valid & pw_ok;
         param_write_reject <= param_write.valid & ~pw_ok;
      end
   end
endmodule

/* testbench/opmsel_chk.sv */
// Assertion checker for the operation mode selector ports
`timescale 1ns/100ps
module opmsel_chk #(
   parameter int N_ASSIGN = 5
) (
   input wire logic                  clock,
   input wire logic                  reset,
   input wire logic                  mode_select_write,
   input wire logic [2:0]            mode_select_value,
   input wire logic                  motor_running,
   input wire logic                  panel_ext_key,
   input wire logic                  forward_start_input,
   input wire logic                  reverse_start_input,
   input wire logic                  panel_interlock_input,
   input wire logic [N_ASSIGN*8-1:0] input_function_assign_settings,
   input wire opmsel_pkg::opmsel_pwr_t  param_write,
   input wire opmsel_pkg::opmsel_mode_t mode,
   input wire logic [2:0]            mode_select_setting,
   input wire opmsel_pkg::opmsel_cmd_t  drive_cmd,
   input wire logic                  param_write_reject
);
   import opmsel_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic [2:0] prev_sel;
   always_ff @(posedge clock) prev_sel <= mode_select_setting;
   // Setting settled for a cycle, so the mode has had time to follow
   wire logic sel_old = prev_sel == mode_select_setting;
   wire logic ilk_off = sel_old && mode_select_setting == 3'h7 && !panel_interlock_input
                        && input_function_assign_settings[7:0] == 8'h0C;
   wire logic ext_bad = param_write.valid && !param_write.writable_ext
                        && param_write.number != 8'h4F;
   AST_FIX_PU: assert property (sel_old && mode_select_setting == 3'h1 |-> mode == OPMSEL_PU)
      else $error("mode not panel under setting 1");
   AST_FIX_CMB1: assert property (sel_old && mode_select_setting == 3'h3 |-> mode == OPMSEL_CMB1)
      else $error("mode not combined 1 under setting 3");
   AST_FIX_CMB2: assert property (sel_old && mode_select_setting == 3'h4 |-> mode == OPMSEL_CMB2)
      else $error("mode not combined 2 under setting 4");
   AST_NO_PU2: assert property (sel_old && mode_select_setting == 3'h2 |-> mode != OPMSEL_PU)
      else $error("panel mode under setting 2");
   AST_REJ5: assert property (mode_select_write && mode_select_value == 3'h5 |=> $stable(mode_select_setting))
      else $error("setting 5 taken");
   AST_PU_KEY: assert property (sel_old && mode_select_setting == 3'h0 && mode == OPMSEL_EXT
      && panel_ext_key && !mode_select_write && !motor_running && !forward_start_input
      && !reverse_start_input |=> mode == OPMSEL_PU) else $error("key did not enter panel mode");
   AST_ILK_OFF: assert property (ilk_off |=> mode == OPMSEL_EXT)
      else $error("interlock off but not external");
   AST_ILK_PWR: assert property (ilk_off && param_write.valid && param_write.number != 8'h4F
      |=> param_write_reject) else $error("write not rejected with interlock off");
   AST_EXT_PWR: assert property (mode == OPMSEL_EXT && ext_bad |=> param_write_reject)
      else $error("write not rejected in external mode");
   AST_EXT_DIR: assert property (mode == OPMSEL_EXT && mode_select_setting == 3'h0
      ##1 mode == OPMSEL_EXT |-> drive_cmd.fwd == $past(forward_start_input)
      && drive_cmd.rev == $past(reverse_start_input)) else $error("external direction wrong");
endmodule
bind opmsel_top opmsel_chk #(.N_ASSIGN(N_ASSIGN)) i_chk (.clock(clock), .reset(reset),
   .mode_select_write(mode_select_write), .mode_select_value(mode_select_value),
   .motor_running(motor_running), .panel_ext_key(panel_ext_key),
   .forward_start_input(forward_start_input), .reverse_start_input(reverse_start_input),
   .panel_interlock_input(panel_interlock_input),
   .input_function_assign_settings(input_function_assign_settings),
   .param_write(param_write), .mode(mode), .mode_select_setting(mode_select_setting),
   .drive_cmd(drive_cmd), .param_write_reject(param_write_reject));

/* testbench/opmsel_host.sv */
// Network host model issuing mode-change commands
`timescale 1ns/100ps
module opmsel_host (
   // Clock
   input  wire logic                clock,
   // Host commands
   output logic                     net_to_net_cmd,
   output logic                     net_to_ext_cmd,
   output opmsel_pkg::opmsel_cmd_t  net_cmd
);
   import opmsel_pkg::*;
   initial {net_to_net_cmd, net_to_ext_cmd} = 2'h0;
   assign net_cmd = '{fwd: 1'h0, rev: 1'h1, freq: 16'h0BB8};
   // One-cycle command pulse, called at a falling edge
   task automatic send(input logic to_ext);
      net_to_ext_cmd = to_ext;
      net_to_net_cmd = !to_ext;
      @(negedge clock);
      {net_to_net_cmd, net_to_ext_cmd} = 2'h0;
      @(negedge clock);
   endtask
endmodule

/* testbench/operation_mode_selector_tb.sv */
// Self-checking bench for the operation mode selector
`timescale 1ns/100ps
module operation_mode_selector_tb;
   import opmsel_pkg::*;
   localparam logic [15:0] AF = 16'h0100, CF = 16'h0200, MF = 16'h0300, PF = 16'h0400;
   logic clock = 1'h0;
   logic reset = 1'h1;
   logic wr, run, kpe, kps, fwd, rev, cis, msa, ilk, ost_in, pkf, pkr, ost, acc, rej, n2n, n2e;
   logic [2:0] wv, sel;
   logic [1:0] pol;
   logic [39:0] fa;
   opmsel_pwr_t pw;
   opmsel_mode_t mode;
   opmsel_cmd_t dc, ncmd;
   int miscompares = 0;
   int n_compared = 0;
   always #5 clock = ~clock;
   opmsel_top i_dut (.clock(clock), .reset(reset), .mode_select_write(wr),
      .mode_select_value(wv), .motor_running(run), .panel_ext_key(kpe), .panel_select_key(kps),
      .net_to_ext_cmd(n2e), .net_to_net_cmd(n2n), .input_function_assign_settings(fa),
      .output_stop_polarity_setting(pol), .panel_interlock_input(ilk), .output_stop_input(ost_in),
      .forward_start_input(fwd), .reverse_start_input(rev), .current_input_select(cis),
      .multi_speed_active(msa), .jog_active(1'h0), .analog_freq(AF), .current_freq(CF),
      .multi_speed_freq(MF), .panel_freq(PF), .panel_fwd_key(pkf), .panel_rev_key(pkr),
      .net_cmd(ncmd), .param_write(pw), .mode(mode), .mode_select_setting(sel),
      .drive_cmd(dc), .output_stop(ost), .param_write_accept(acc), .param_write_reject(rej));
   opmsel_host i_host (.clock(clock), .net_to_net_cmd(n2n), .net_to_ext_cmd(n2e), .net_cmd(ncmd));
   task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic end_sim;
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic rst;
      reset = 1'h1;
      cyc(5);
      reset = 1'h0;
      cyc(2);
      chk("mode", OPMSEL_EXT, mode);
   endtask
   task automatic cm(input opmsel_mode_t m);
      chk("mode", m, mode);
   endtask
   task automatic cd(input logic f, input logic r, input logic [15:0] q);
      chk("drive", {f, r, q}, dc);
   endtask
   task automatic setsel(input logic [2:0] v);
      wr = 1'h1;
      wv = v;
      cyc(1);
      wr = 1'h0;
      cyc(2);
   endtask
   // Select key when ps is set, otherwise the panel/external key
   task automatic key(input logic ps);
      kpe = !ps;
      kps = ps;
      cyc(1);
      {kpe, kps} = 2'h0;
      cyc(1);
   endtask
   task automatic pwr(input logic [7:0] num, input logic we, input logic ok);
      pw = '{1'h1, num, we, 1'h1};
      cyc(1);
      chk("accept", ok, acc);
      chk("reject", !ok, rej);
      pw.valid = 1'h0;
      cyc(1);
   endtask
   // Whole run is under a hundred cycles
   initial begin
      cyc(2000);
      miscompares++;
      end_sim;
   end
   initial begin
      {wr, run, kpe, kps, fwd, rev, cis, msa, ilk, ost_in, pkf, pkr} = '0;
      {wv, pol, fa, pw} = '0;
      rst;
      fwd = 1'h1;
      cyc(1);
      cd(1'h1, 1'h0, AF);
      pwr(8'h10, 1'h0, 1'h0);
      pwr(8'h10, 1'h1, 1'h1);
      fwd = 1'h0;
      key(1'h0);
      cm(OPMSEL_PU);
      rev = 1'h1;
      key(1'h0);
      cd(1'h0, 1'h1, AF);
      setsel(3'h5);
      chk("setting", 3'h0, sel);
      setsel(3'h2);
      key(1'h0);
      cm(OPMSEL_EXT);
      setsel(3'h1);
      key(1'h0);
      cm(OPMSEL_PU);
      {fwd, rev} = 2'h2;
      setsel(3'h3);
      cd(1'h1, 1'h0, PF);
      msa = 1'h1;
      cyc(1);
      cd(1'h1, 1'h0, MF);
      {msa, cis} = 2'h1;
      cyc(1);
      cd(1'h1, 1'h0, CF);
      {fwd, cis, pkf} = 3'h1;
      setsel(3'h4);
      cd(1'h1, 1'h0, AF);
      pkf = 1'h0;
      rst;
      setsel(3'h6);
      {fwd, run} = 2'h3;
      cyc(1);
      key(1'h0);
      cm(OPMSEL_PU);
      {fwd, rev} = 2'h1;
      cyc(1);
      cd(1'h1, 1'h0, AF);
      i_host.send(1'h0);
      cd(1'h1, 1'h0, AF);
      key(1'h1);
      cd(1'h1, 1'h0, AF);
      key(1'h0);
      cd(1'h0, 1'h1, AF);
      i_host.send(1'h0);
      {fwd, rev} = 2'h2;
      cyc(1);
      cd(1'h0, 1'h1, AF);
      i_host.send(1'h1);
      cd(1'h1, 1'h0, AF);
      reset = 1'h1;
      cyc(1);
      cd(1'h0, 1'h0, 16'h0000);
      {fwd, run, ilk} = 3'h1;
      fa = 40'h0C;
      rst;
      setsel(3'h7);
      chk("stop", 1'h1, ost);
      fwd = 1'h1;
      key(1'h0);
      cm(OPMSEL_EXT);
      fwd = 1'h0;
      key(1'h0);
      cm(OPMSEL_PU);
      ilk = 1'h0;
      cyc(1);
      cm(OPMSEL_EXT);
      pwr(8'h10, 1'h1, 1'h0);
      pwr(8'h4F, 1'h1, 1'h1);
      fa = 40'h18;
      ost_in = 1'h1;
      key(1'h0);
      cm(OPMSEL_PU);
      ost_in = 1'h0;
      cyc(1);
      cm(OPMSEL_EXT);
      pol = 2'h2;
      key(1'h0);
      cm(OPMSEL_PU);
      end_sim;
   end
endmodule
